/* File: crgpc_consts.vh */
// Constants for the clock and reset generator with PLL and watchdog
`ifndef CRGPC_CONSTS_VH
`define CRGPC_CONSTS_VH

// Register indices; the byte address is the index times four
`define CRGPC_IDX_TEST_A       8'h09
`define CRGPC_IDX_TEST_B       8'h0A
`define CRGPC_IDX_SERVICE      8'h0B
`define CRGPC_IDX_WDOG_CTL     8'h08
`define CRGPC_IDX_PLL_DIV      8'h0C
`define CRGPC_IDX_PLL_CTL      8'h0D
`define CRGPC_IDX_STATUS       8'h0E
`define CRGPC_IDX_LOCK_TOL     8'h0F

// Service codes
`define CRGPC_SVC_FIRST        8'h55
`define CRGPC_SVC_SECOND       8'hAA

// Watchdog time-out lengths in oscillator cycles, per rate code
`define CRGPC_WD_RATE1         25'h0004000
`define CRGPC_WD_RATE2         25'h0010000
`define CRGPC_WD_RATE3         25'h0040000
`define CRGPC_WD_RATE4         25'h0100000
`define CRGPC_WD_RATE5         25'h0400000
`define CRGPC_WD_RATE6         25'h0800000
`define CRGPC_WD_RATE7         25'h1000000

// Watchdog control fields
`define CRGPC_RATE_OFF         3'h0
`define CRGPC_WIN_BIT          7

// PLL divider field positions in the divider register
`define CRGPC_REFDIV_LSB       0
`define CRGPC_SYNDIV_LSB       8
`define CRGPC_POSTDIV_LSB      16
`define CRGPC_REFRNG_LSB       24
`define CRGPC_VCORNG_LSB       26

// PLL control bits
`define CRGPC_CTL_SEL          0
`define CRGPC_CTL_PWR          1
`define CRGPC_CTL_LOCK_INTERRUPT_ENABLE       2
`define CRGPC_CTL_CME          3
`define CRGPC_CTL_SELF_CLOCK_MODE_ENABLE         4
`define CRGPC_CTL_RESET        5'h1A

// Lock detector
`define CRGPC_LOCK_WIN         16'h0400
`define CRGPC_LOCK_TOL_RST     16'h0302

// Clock switching freeze: 8 block clock cycles
`define CRGPC_SWITCH_CYC       4'h8

// Clock quality check window and good-edge count
`define CRGPC_CHECK_WIN        50000
`define CRGPC_OSC_OK_EDGES     4096

`endif

/* File: crgpc_top.v */
// Clock and reset generator: watchdog, PLL dividers, lock, clock checks
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "crgpc_consts.vh"

// Overview of operation
// - Test registers read zero and ignore writes outside special modes.
// - Service register reads zero and accepts writes anytime.
// - Service writes do nothing while watchdog rate select is zero.
// - Enabled watchdog resets on any service value except 55 or AA.
// - 55 then AA restarts period; other activity and repeats allowed.
// - Windowed mode: any service write in first 75% resets.
// - Reference divider divides oscillator by field plus one.
// - Loop divider divides VCO by two times field plus one.
// - Post divider divides VCO by twice field; zero means one.
// - PLL selected: bus runs half PLL.
// - Lock bit read-only, set within tolerance, cleared outside.
// - Lock interrupt pulses on every lock change when enabled.
// - PLL power stays on while PLL drives the system clock.
// - Clock select change freezes clocks for at most 8 cycles.
// - Bus clock drives external pin; self clock replaces oscillator.
// - Monitor failure enters self clock mode or resets system.
// - Monitor enable gates failure; edges present mean no failure.
// - Quality check starts on power-on, low voltage, wake, failure.
// - Check window 50000 PLL cycles; 4096 oscillator edges is good.
// - Reaching the good count ends the window at once.
// - Nonzero rate starts watchdog; time-out resets system.
// - In windowed mode, completed pair restarts the window.
module crgpc_top
(
	input  wire        ref_clk_in,        // Block clock, 50 MHz
	input  wire        arst_n_in,         // Async reset, active low
	input  wire        psel_in,           // APB select
	input  wire        penable_in,        // APB enable
	input  wire        pwrite_in,         // APB direction
	input  wire [7:0]  paddr_in,          // APB byte address
	input  wire [31:0] pwdata_in,         // APB write data
	output wire        pready_out,        // APB ready
	output reg  [31:0] prdata_out,        // APB read data
	output wire        pslverr_out,       // APB error
	input  wire        special_mode_in,   // Device in special mode
	input  wire        osc_tick_in,       // Oscillator clock edge enable
	input  wire        vco_tick_in,       // VCO clock edge enable
	input  wire        pll_tick_in,       // PLL clock edge enable
	input  wire        cm_fail_in,        // Monitor: no oscillator edges
	input  wire        por_in,            // Power-on reset event
	input  wire        lvr_in,            // Low voltage reset event
	input  wire        stop_wake_in,      // Wake from full stop event
	output reg         ref_tick_out,      // PLL reference clock enable
	output reg         fb_tick_out,       // PLL feedback clock enable
	output reg         pll_output_clock_tick_out,   // Post-divided PLL enable
	output reg         bus_tick_out,      // Bus clock enable
	output reg         external_bus_clock_output_out,          // External bus clock pin
	output wire        periph_osc_tick_out, // Peripheral oscillator clock
	output wire        pll_power_out,     // PLL powered
	output wire        pll_sel_out,       // System clock from PLL
	output wire        clk_freeze_out,    // Clocks frozen, CPU halted
	output reg         lock_irq_out,      // Lock change request pulse
	output wire        self_clock_out,    // Self clock mode active
	output reg         sys_reset_out,     // System reset request pulse
	output wire        osc_ok_out         // Oscillator judged good
);

	//----------------------------------------
	// Registers
	//----------------------------------------
	reg  [2:0]  rate_ff;
	reg         win_ff;
	reg  [7:0]  test_a_ff;
	reg  [7:0]  test_b_ff;
	reg  [31:0] div_ff;
	reg  [4:0]  ctl_ff;
	reg  [31:0] tol_ff;
	reg         lock_ff;
	reg         scm_ff;
	reg         osc_ok_ff;
	reg  [24:0] wd_cnt_ff;
	reg         armed55_ff;
	reg  [3:0]  frz_ff;
	reg         sel_act_ff;

	wire        wr_en = psel_in & penable_in & pwrite_in;
	wire [7:0]  wbyte = pwdata_in[7:0];

	assign pready_out  = 1'b1;
	assign pslverr_out = 1'b0;

	// Timeout length in oscillator cycles for a rate code
	function [24:0] wd_period;
		input [2:0] r;
		begin
			case (r)
				3'h1:    wd_period = `CRGPC_WD_RATE1;
				3'h2:    wd_period = `CRGPC_WD_RATE2;
				3'h3:    wd_period = `CRGPC_WD_RATE3;
				3'h4:    wd_period = `CRGPC_WD_RATE4;
				3'h5:    wd_period = `CRGPC_WD_RATE5;
				3'h6:    wd_period = `CRGPC_WD_RATE6;
				default: wd_period = `CRGPC_WD_RATE7;
			endcase
		end
	endfunction

	// Register decode; every index is word spaced on the bus
	function reg_hit;
		input [7:0] a;
		input [7:0] idx;
		begin
			reg_hit = (a == {idx[5:0], 2'b00});
		end
	endfunction

	wire [24:0] period   = wd_period(rate_ff);
	wire        wd_on    = (rate_ff != `CRGPC_RATE_OFF);
	// Open window is the last quarter of the period
	wire        in_win   = (wd_cnt_ff >= (period - (period >> 2)));
	wire        svc_wr   = wr_en && reg_hit(paddr_in, `CRGPC_IDX_SERVICE);
	wire        svc_code = (wbyte == `CRGPC_SVC_FIRST) ||
	                       (wbyte == `CRGPC_SVC_SECOND);

	//----------------------------------------
	// Configuration register writes
	//----------------------------------------
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rate_ff   <= 3'h0;
			win_ff    <= 1'b0;
			test_a_ff <= 8'h00;
			test_b_ff <= 8'h00;
			div_ff    <= 32'h00000000;
			ctl_ff    <= `CRGPC_CTL_RESET;
			tol_ff    <= {`CRGPC_LOCK_TOL_RST, `CRGPC_LOCK_WIN};
		end
		else if (wr_en)
		begin
			if (reg_hit(paddr_in, `CRGPC_IDX_WDOG_CTL))
			begin
				rate_ff <= wbyte[2:0];
				win_ff  <= wbyte[`CRGPC_WIN_BIT];
			end
			else if (special_mode_in &&
			         reg_hit(paddr_in, `CRGPC_IDX_TEST_A))
				test_a_ff <= wbyte;
			else if (special_mode_in &&
			         reg_hit(paddr_in, `CRGPC_IDX_TEST_B))
				test_b_ff <= wbyte;
			else if (reg_hit(paddr_in, `CRGPC_IDX_PLL_DIV))
				div_ff <= pwdata_in;
			else if (reg_hit(paddr_in, `CRGPC_IDX_PLL_CTL))
				ctl_ff <= pwdata_in[4:0];
			else if (reg_hit(paddr_in, `CRGPC_IDX_LOCK_TOL))
				tol_ff <= pwdata_in;
		end
	end

	//----------------------------------------
	// Watchdog counter and service sequence
	//----------------------------------------
	reg wd_rst;
	always @*
	begin
		wd_rst = 1'b0;
		if (svc_wr && wd_on)
		begin
			if (!svc_code)
				wd_rst = 1'b1;
			else if (win_ff && !in_win)
				wd_rst = 1'b1;
		end
		if (wd_on && osc_tick_in && wd_cnt_ff == period - 25'h1)
			wd_rst = 1'b1;
	end

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wd_cnt_ff  <= 25'h0;
			armed55_ff <= 1'b0;
		end
		else if (!wd_on || wd_rst ||
		         (wr_en && reg_hit(paddr_in, `CRGPC_IDX_WDOG_CTL)))
		begin
			// Rate write restarts the period
			wd_cnt_ff  <= 25'h0;
			armed55_ff <= 1'b0;
		end
		else if (svc_wr)
		begin
			if (wbyte == `CRGPC_SVC_FIRST)
				armed55_ff <= 1'b1;
			else if (armed55_ff)
			begin
				wd_cnt_ff  <= 25'h0;
				armed55_ff <= 1'b0;
			end
		end
		else if (osc_tick_in)
			wd_cnt_ff <= wd_cnt_ff + 25'h1;
	end

	//----------------------------------------
	// PLL dividers
	//----------------------------------------
	wire [5:0] ref_div  = div_ff[`CRGPC_REFDIV_LSB +: 6];
	wire [5:0] syn_div  = div_ff[`CRGPC_SYNDIV_LSB +: 6];
	wire [4:0] post_div = div_ff[`CRGPC_POSTDIV_LSB +: 5];
	reg  [5:0] ref_cnt_ff;
	reg  [6:0] fb_cnt_ff;
	reg  [5:0] post_cnt_ff;
	// Self clock mode runs the VCO at its floor; dividers keep going
	wire       pll_run = pll_power_out | scm_ff;

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ref_cnt_ff      <= 6'h0;
			fb_cnt_ff       <= 7'h0;
			post_cnt_ff     <= 6'h0;
			ref_tick_out    <= 1'b0;
			fb_tick_out     <= 1'b0;
			pll_output_clock_tick_out <= 1'b0;
		end
		else
		begin
			ref_tick_out    <= 1'b0;
			fb_tick_out     <= 1'b0;
			pll_output_clock_tick_out <= 1'b0;
			if (osc_tick_in)
			begin
				if (ref_cnt_ff >= ref_div)
				begin
					ref_cnt_ff   <= 6'h0;
					ref_tick_out <= 1'b1;
				end
				else
					ref_cnt_ff <= ref_cnt_ff + 6'h1;
			end
			if (vco_tick_in && pll_run)
			begin
				// divide by 2 times field plus one
				if (fb_cnt_ff >= {syn_div, 1'b1})
				begin
					fb_cnt_ff   <= 7'h0;
					fb_tick_out <= 1'b1;
				end
				else
					fb_cnt_ff <= fb_cnt_ff + 7'h1;
				if (post_div == 5'h0 ||
				    post_cnt_ff >= {post_div, 1'b0} - 6'h1)
				begin
					post_cnt_ff     <= 6'h0;
					pll_output_clock_tick_out <= 1'b1;
				end
				else
					post_cnt_ff <= post_cnt_ff + 6'h1;
			end
		end
	end

	//----------------------------------------
	// Lock detector
	//----------------------------------------
	reg [15:0] lk_win_ff;
	reg [15:0] lk_ref_ff;
	reg [15:0] lk_fb_ff;
	wire [15:0] lk_diff = (lk_ref_ff > lk_fb_ff) ? lk_ref_ff - lk_fb_ff
	                                             : lk_fb_ff - lk_ref_ff;

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			lk_win_ff    <= 16'h0;
			lk_ref_ff    <= 16'h0;
			lk_fb_ff     <= 16'h0;
			lock_ff      <= 1'b0;
			lock_irq_out <= 1'b0;
		end
		else
		begin
			lock_irq_out <= 1'b0;
			if (lk_win_ff >= tol_ff[15:0])
			begin
				lk_win_ff <= 16'h0;
				lk_ref_ff <= 16'h0;
				lk_fb_ff  <= 16'h0;
				if (!lock_ff && pll_run &&
				    lk_diff <= {8'h00, tol_ff[23:16]})
				begin
					lock_ff      <= 1'b1;
					lock_irq_out <= ctl_ff[`CRGPC_CTL_LOCK_INTERRUPT_ENABLE];
				end
				else if (lock_ff && (!pll_run ||
				         lk_diff > {8'h00, tol_ff[31:24]}))
				begin
					lock_ff      <= 1'b0;
					lock_irq_out <= ctl_ff[`CRGPC_CTL_LOCK_INTERRUPT_ENABLE];
				end
			end
			else
			begin
				lk_win_ff <= lk_win_ff + {15'h0, ref_tick_out};
				lk_ref_ff <= lk_ref_ff + {15'h0, ref_tick_out};
				lk_fb_ff  <= lk_fb_ff + {15'h0, fb_tick_out};
			end
		end
	end

	//----------------------------------------
	// Clock select, freeze and bus clock
	//----------------------------------------
	wire want_sel = ctl_ff[`CRGPC_CTL_SEL] & ~scm_ff;
	assign pll_power_out  = ctl_ff[`CRGPC_CTL_PWR] | sel_act_ff;
	assign pll_sel_out    = sel_act_ff;
	assign clk_freeze_out = (frz_ff != 4'h0);

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			frz_ff     <= 4'h0;
			sel_act_ff <= 1'b0;
		end
		else if (frz_ff != 4'h0)
		begin
			frz_ff <= frz_ff - 4'h1;
			if (frz_ff == 4'h1)
				sel_act_ff <= want_sel;
		end
		else if (want_sel != sel_act_ff)
			frz_ff <= `CRGPC_SWITCH_CYC;
	end

	// Bus clock source tick and divide-by-two
	wire src_tick = sel_act_ff ? pll_output_clock_tick_out :
	                (scm_ff ? pll_output_clock_tick_out : osc_tick_in);
	reg  half_ff;
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			half_ff      <= 1'b0;
			bus_tick_out <= 1'b0;
			external_bus_clock_output_out     <= 1'b0;
		end
		else
		begin
			bus_tick_out <= 1'b0;
			if (src_tick && !clk_freeze_out)
			begin
				half_ff <= ~half_ff;
				bus_tick_out <= half_ff;
				external_bus_clock_output_out <= half_ff;
			end
		end
	end

	assign periph_osc_tick_out = scm_ff ? pll_output_clock_tick_out : osc_tick_in;

	//----------------------------------------
	// Clock monitor and quality checker
	//----------------------------------------
	// monitor enable gates failure
	wire cm_evt = cm_fail_in & ctl_ff[`CRGPC_CTL_CME] & ~osc_tick_in;
	reg  [15:0] chk_win_ff;
	reg  [12:0] chk_edge_ff;
	reg         chk_run_ff;
	reg         cm_rst;
	assign self_clock_out = scm_ff;
	assign osc_ok_out     = osc_ok_ff;

	always @*
	begin
		cm_rst = cm_evt & ~ctl_ff[`CRGPC_CTL_SELF_CLOCK_MODE_ENABLE];
	end

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			scm_ff      <= 1'b0;
			osc_ok_ff   <= 1'b0;
			chk_run_ff  <= 1'b0;
			chk_win_ff  <= 16'h0;
			chk_edge_ff <= 13'h0;
		end
		else if (por_in || lvr_in || stop_wake_in || cm_evt)
		begin
			chk_run_ff  <= 1'b1;
			osc_ok_ff   <= 1'b0;
			chk_win_ff  <= 16'h0;
			chk_edge_ff <= 13'h0;
			if (cm_evt && ctl_ff[`CRGPC_CTL_SELF_CLOCK_MODE_ENABLE])
				scm_ff <= 1'b1;
		end
		else if (chk_run_ff)
		begin
			if (chk_edge_ff + {12'h0, osc_tick_in} >= `CRGPC_OSC_OK_EDGES)
			begin
				chk_run_ff <= 1'b0;
				osc_ok_ff  <= 1'b1;
				scm_ff     <= 1'b0;
			end
			else if (pll_tick_in &&
			         chk_win_ff == `CRGPC_CHECK_WIN - 1)
			begin
				chk_win_ff  <= 16'h0;
				chk_edge_ff <= 13'h0;
			end
			else
			begin
				chk_win_ff  <= chk_win_ff + {15'h0, pll_tick_in};
				chk_edge_ff <= chk_edge_ff + {12'h0, osc_tick_in};
			end
		end
	end

	// System reset request from watchdog or monitor
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			sys_reset_out <= 1'b0;
		else
			sys_reset_out <= wd_rst | cm_rst;
	end

	//----------------------------------------
	// APB read mux
	//----------------------------------------
	always @*
	begin
		prdata_out = 32'h00000000;
		if (reg_hit(paddr_in, `CRGPC_IDX_WDOG_CTL))
			prdata_out = {24'h0, win_ff, 4'h0, rate_ff};
		else if (special_mode_in &&
		         reg_hit(paddr_in, `CRGPC_IDX_TEST_A))
			prdata_out = {24'h0, test_a_ff};
		else if (special_mode_in &&
		         reg_hit(paddr_in, `CRGPC_IDX_TEST_B))
			prdata_out = {24'h0, test_b_ff};
		else if (reg_hit(paddr_in, `CRGPC_IDX_PLL_DIV))
			prdata_out = div_ff;
		else if (reg_hit(paddr_in, `CRGPC_IDX_PLL_CTL))
			prdata_out = {27'h0, ctl_ff};
		else if (reg_hit(paddr_in, `CRGPC_IDX_STATUS))
			prdata_out = {27'h0, clk_freeze_out, sel_act_ff, osc_ok_ff,
			              scm_ff, lock_ff};
		else if (reg_hit(paddr_in, `CRGPC_IDX_LOCK_TOL))
			prdata_out = tol_ff;
	end

endmodule
`default_nettype wire

/* File: crgpc_chk.sv */
// Port checker for the clock and reset generator
`timescale 1ns/1ps
`default_nettype none
module crgpc_chk
(
	input wire        ref_clk_in,          // Block clock
	input wire        arst_n_in,           // Reset, active low
	input wire        psel_in,             // APB select
	input wire        penable_in,          // APB enable
	input wire        pwrite_in,           // APB direction
	input wire [7:0]  paddr_in,            // APB address
	input wire [31:0] pwdata_in,           // APB write data
	input wire        pready_out,          // APB ready
	input wire [31:0] prdata_out,          // APB read data
	input wire        special_mode_in,     // Special mode
	input wire        osc_tick_in,         // Oscillator edge
	input wire        cm_fail_in,          // Monitor fail
	input wire        periph_osc_tick_out, // Peripheral clock
	input wire        pll_power_out,       // PLL powered
	input wire        pll_sel_out,         // PLL selected
	input wire        clk_freeze_out,      // Clocks frozen
	input wire        lock_irq_out,        // Lock change pulse
	input wire        self_clock_out,      // Self clock mode
	input wire        sys_reset_out        // Reset request
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	logic       rd_acc;
	logic       wr_acc;
	logic [2:0] rate_ff;
	logic [4:0] ctl_ff;

	// Completed APB access, split by direction
	assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;
	assign rd_acc = psel_in & penable_in & pready_out & ~pwrite_in;

	// Shadows of rate and control, since the checker sees only the bus
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rate_ff <= 3'h0;
			ctl_ff  <= 5'h1A;
		end
		else
		begin
			if (wr_acc && paddr_in == 8'h20)
				rate_ff <= pwdata_in[2:0];
			if (wr_acc && paddr_in == 8'h34)
				ctl_ff <= pwdata_in[4:0];
		end
	end

	// Register reads, service writes and clock control relations
	AST_TEST_ZERO: assert property (
		rd_acc && !special_mode_in && paddr_in inside {8'h24, 8'h28}
		|-> prdata_out == 32'h0) else $error("test register not zero");
	AST_SVC_READ: assert property (
		rd_acc && paddr_in == 8'h2C |-> prdata_out == 32'h0)
		else $error("service register read not zero");
	AST_SVC_OFF: assert property (
		wr_acc && paddr_in == 8'h2C && rate_ff == 3'h0 |=> !sys_reset_out)
		else $error("service write reset while watchdog off");
	AST_SVC_BAD: assert property (
		wr_acc && paddr_in == 8'h2C && rate_ff != 3'h0 &&
		!(pwdata_in[7:0] inside {8'h55, 8'hAA}) |=> sys_reset_out)
		else $error("bad service code gave no reset");
	AST_LOCK_EN: assert property (
		lock_irq_out |-> ctl_ff[2]) else $error("lock request while masked");
	AST_PWR_HOLD: assert property (
		pll_sel_out |-> pll_power_out) else $error("PLL off while selected");
	AST_FREEZE: assert property (
		$rose(clk_freeze_out) |-> ##[1:12] !clk_freeze_out)
		else $error("clock switch freeze too long");
	AST_PERIPH: assert property (
		!self_clock_out && !clk_freeze_out
		|-> periph_osc_tick_out == osc_tick_in)
		else $error("peripheral clock not oscillator");
	AST_CM_SCM: assert property (
		$rose(cm_fail_in) && !osc_tick_in && ctl_ff[3] && ctl_ff[4]
		|-> ##[1:4] self_clock_out) else $error("no self clock on fail");
	AST_CM_RST: assert property (
		$rose(cm_fail_in) && !osc_tick_in && ctl_ff[3] && !ctl_ff[4]
		|-> ##[1:4] sys_reset_out) else $error("no reset on monitor fail");
	AST_CM_OFF: assert property (
		!ctl_ff[3] && rate_ff == 3'h0 && !self_clock_out
		|=> !self_clock_out && !sys_reset_out)
		else $error("failure seen with monitor off");

	// Main scenarios reached
	COV_RST: cover property (sys_reset_out);
	COV_SCM: cover property ($rose(self_clock_out));
	COV_IRQ: cover property (lock_irq_out);
	COV_FRZ: cover property ($fell(clk_freeze_out));
endmodule

bind crgpc_top crgpc_chk u_crgpc_chk (
	.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pready_out(pready_out),
	.prdata_out(prdata_out), .special_mode_in(special_mode_in),
	.osc_tick_in(osc_tick_in), .cm_fail_in(cm_fail_in),
	.periph_osc_tick_out(periph_osc_tick_out),
	.pll_power_out(pll_power_out), .pll_sel_out(pll_sel_out),
	.clk_freeze_out(clk_freeze_out), .lock_irq_out(lock_irq_out),
	.self_clock_out(self_clock_out), .sys_reset_out(sys_reset_out));
`default_nettype wire

/* File: crgpc_tb.sv */
// Self-checking bench for the clock and reset generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
	logic        ref_clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] rd;
	logic        vco_tick_in = 1'b1;
	logic        osc_tick_in = 1'b1;
	logic        special_mode_in = 1'b0;
	logic        ecl_q = 1'b0;
	wire         external_bus_clock_output_out;
	logic [3:0]  ev = 4'h0;
	wire  [31:0] prdata_out;
	wire         pready_out, ref_tick_out, fb_tick_out, pll_output_clock_tick_out;
	wire         bus_tick_out, pll_power_out, pll_sel_out, clk_freeze_out;
	wire         lock_irq_out, self_clock_out, sys_reset_out, osc_ok_out;
	int          err_count = 0, cmp_count = 0, i;
	int          n_rst = 0, n_irq = 0, n_ref = 0, n_fb = 0, n_pll = 0;
	int          n_bus = 0, n_ecl = 0;

	crgpc_top u_crgpc_top (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pready_out(pready_out),
		.prdata_out(prdata_out), .pslverr_out(),
		.special_mode_in(special_mode_in), .osc_tick_in(osc_tick_in),
		.vco_tick_in(vco_tick_in), .pll_tick_in(1'b1),
		.cm_fail_in(ev[3]), .por_in(ev[0]), .lvr_in(ev[1]),
		.stop_wake_in(ev[2]), .ref_tick_out(ref_tick_out),
		.fb_tick_out(fb_tick_out), .pll_output_clock_tick_out(pll_output_clock_tick_out),
		.bus_tick_out(bus_tick_out), .external_bus_clock_output_out(external_bus_clock_output_out),
		.periph_osc_tick_out(),
		.pll_power_out(pll_power_out), .pll_sel_out(pll_sel_out),
		.clk_freeze_out(clk_freeze_out), .lock_irq_out(lock_irq_out),
		.self_clock_out(self_clock_out), .sys_reset_out(sys_reset_out),
		.osc_ok_out(osc_ok_out));

	// 50 MHz clock
	always #10 ref_clk_in = ~ref_clk_in;

	// Pulse counters; measurements allow one pulse of phase slip
	always @(posedge ref_clk_in)
	begin
		n_rst += (sys_reset_out === 1'b1);
		n_irq += (lock_irq_out === 1'b1);
		n_ref += (ref_tick_out === 1'b1);
		n_fb  += (fb_tick_out === 1'b1);
		n_pll += (pll_output_clock_tick_out === 1'b1);
		n_bus += (bus_tick_out === 1'b1);
		n_ecl += (external_bus_clock_output_out === 1'b1 && ecl_q === 1'b0);
		ecl_q <= external_bus_clock_output_out;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	// One APB transfer; read data lands in rd
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do @(posedge ref_clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic rst;
		arst_n_in <= 1'b0;
		cyc(3);
		arst_n_in <= 1'b1;
		n_rst = 0;
		n_irq = 0;
	endtask

	// One-cycle event: 0 power-on, 1 low voltage, 2 wake, 3 monitor fail
	// A monitor failure comes with a silent oscillator
	task automatic pulse(input int k);
		ev <= 4'h1 << k;
		osc_tick_in <= (k != 3);
		cyc(1);
		ev <= 4'h0;
		osc_tick_in <= 1'b1;
	endtask

	task automatic meas(input int n);
		cyc(8);
		n_ref = 0;
		n_fb = 0;
		n_pll = 0;
		n_bus = 0;
		n_ecl = 0;
		cyc(n);
	endtask

	function automatic bit near(input int c, input int e);
		return c >= e - 1 && c <= e + 1;
	endfunction

	task automatic stop_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, well beyond the longest sequence
	initial
	begin
		cyc(95000);
		err_count++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		rst();
		apb(0, 8'h34, 32'h0);
		`CHK(rd[4:0], 5'h1A)
		special_mode_in <= 1'b1;
		apb(1, 8'h24, 32'h5A);
		special_mode_in <= 1'b0;
		for (i = 9; i < 12; i++)
		begin
			apb(1, {i[5:0], 2'b00}, 32'hFF);
			apb(0, {i[5:0], 2'b00}, 32'h0);
			`CHK(rd, 32'h0)
		end
		special_mode_in <= 1'b1;
		apb(0, 8'h24, 32'h0);
		`CHK(rd, 32'h5A)
		special_mode_in <= 1'b0;
		cyc(3);
		`CHK(n_rst, 0)
		apb(1, 8'h20, 32'h1);
		for (i = 0; i < 2; i++)
		begin
			cyc(10000);
			apb(1, 8'h2C, 32'h55);
			apb(1, 8'h2C, 32'h55);
			apb(0, 8'h30, 32'h0);
			apb(1, 8'h2C, 32'hAA);
			apb(1, 8'h2C, 32'hAA);
		end
		`CHK(n_rst, 0)
		cyc(10000);
		apb(1, 8'h2C, 32'hAA);
		cyc(7000);
		`CHK(n_rst > 0, 1'b1)
		rst();
		apb(1, 8'h20, 32'h7);
		apb(1, 8'h2C, 32'h12);
		cyc(2);
		`CHK(n_rst, 1)
		rst();
		apb(1, 8'h20, 32'h81);
		apb(1, 8'h2C, 32'h55);
		cyc(2);
		`CHK(n_rst, 1)
		rst();
		apb(1, 8'h20, 32'h81);
		cyc(12400);
		apb(1, 8'h2C, 32'h55);
		apb(1, 8'h2C, 32'hAA);
		cyc(2);
		`CHK(n_rst, 0)
		apb(1, 8'h2C, 32'h55);
		cyc(2);
		`CHK(n_rst, 1)
		rst();
		for (i = 0; i < 2; i++)
		begin
			apb(1, 8'h30, i ? 32'h00020103 : 32'h0);
			meas(400);
			`CHK(near(n_ref, i ? 100 : 400), 1'b1)
			`CHK(near(n_fb, i ? 100 : 200), 1'b1)
			`CHK(near(n_pll, i ? 100 : 400), 1'b1)
		end
		apb(1, 8'h34, 32'h1E);
		apb(1, 8'h3C, 32'h03020010);
		apb(1, 8'h30, 32'h01010103);
		cyc(300);
		apb(1, 8'h38, 32'h0);
		apb(0, 8'h38, 32'h0);
		`CHK(rd[0], 1'b1)
		`CHK(n_irq, 1)
		apb(1, 8'h34, 32'h1F);
		cyc(20);
		`CHK(pll_sel_out, 1'b1)
		meas(400);
		`CHK(near(n_bus, 100), 1'b1)
		`CHK(near(n_ecl, 100), 1'b1)
		apb(1, 8'h34, 32'h1D);
		cyc(2);
		`CHK(pll_power_out, 1'b1)
		vco_tick_in <= 1'b0;
		cyc(300);
		`CHK(n_irq, 2)
		apb(0, 8'h38, 32'h0);
		`CHK(rd[0], 1'b0)
		vco_tick_in <= 1'b1;
		rst();
		pulse(3);
		cyc(3);
		`CHK(self_clock_out, 1'b1)
		cyc(4300);
		`CHK(self_clock_out, 1'b0)
		for (i = 0; i < 3; i++)
		begin
			rst();
			pulse(i);
			cyc(4000);
			`CHK(osc_ok_out, 1'b0)
			cyc(200);
			`CHK(osc_ok_out, 1'b1)
		end
		apb(1, 8'h34, 32'h0A);
		pulse(3);
		cyc(4);
		`CHK(n_rst, 1)
		apb(1, 8'h34, 32'h02);
		pulse(3);
		cyc(4);
		`CHK(n_rst, 1)
		`CHK(self_clock_out, 1'b0)
		stop_test();
	end
endmodule
`default_nettype wire
